// File: rtl/dual_pll_divider_chain.sv
// Divider chain of a dual synthesizer with serial and register access
//
// The register offsets and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ps
module dual_pll_divider_chain (
	// Clock and reset
	input  wire logic                             aclk,
	input  wire logic                             aresetn,
	// Write address channel
	input  wire logic [pll_div_pkg::AXI_ADDR_W-1:0] awaddr,
	input  wire logic [2:0]                       awprot,
	input  wire logic                             awvalid,
	output logic                                  awready,
	// Write data channel
	input  wire logic [pll_div_pkg::AXI_DATA_W-1:0] wdata,
	input  wire logic [3:0]                       wstrb,
	input  wire logic                             wvalid,
	output logic                                  wready,
	// Write response channel
	output logic [1:0]                            bresp,
	output logic                                  bvalid,
	input  wire logic                             bready,
	// Read address channel
	input  wire logic [pll_div_pkg::AXI_ADDR_W-1:0] araddr,
	input  wire logic [2:0]                       arprot,
	input  wire logic                             arvalid,
	output logic                                  arready,
	// Read data channel
	output logic [pll_div_pkg::AXI_DATA_W-1:0]    rdata,
	output logic [1:0]                            rresp,
	output logic                                  rvalid,
	input  wire logic                             rready,
	// Device pins
	input  wire logic                             reference_clock_input,
	input  wire logic [pll_div_pkg::NUM_SYNTH-1:0] rf_input,
	input  wire logic                             serial_clock,
	input  wire logic                             serial_data,
	input  wire logic                             latch_strobe,
	// Phase comparator inputs
	output logic [pll_div_pkg::NUM_SYNTH-1:0]     comparison_ref,
	output logic [pll_div_pkg::NUM_SYNTH-1:0]     comparison_fb
);
	import pll_div_pkg::*;

	localparam int PIN_N = NUM_SYNTH + 4;

	// Pin synchronisers and edge detection
	logic [PIN_N-1:0]         pins;
	logic [PIN_N-1:0]         sync1_q;
	logic [PIN_N-1:0]         sync2_q;
	logic [PIN_N-1:0]         sync3_q;
	logic [PIN_N-1:0]         rise;
	logic                     ref_tick;
	logic [NUM_SYNTH-1:0]     rf_tick;
	logic                     sclk_rise;
	logic                     strobe_rise;
	logic                     data_bit;

	assign pins = {latch_strobe, serial_data, serial_clock, rf_input, reference_clock_input};

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync1_q <= '0;
			sync2_q <= '0;
			sync3_q <= '0;
		end else begin
			sync1_q <= pins;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
		end
	end

	assign rise        = sync2_q & ~sync3_q;
	assign ref_tick    = rise[0];
	assign rf_tick     = rise[NUM_SYNTH:1];
	assign sclk_rise   = rise[NUM_SYNTH+1];
	assign data_bit    = sync2_q[NUM_SYNTH+2];
	assign strobe_rise = rise[NUM_SYNTH+3];

	// Serial shift register and control registers
	logic [SHIFT_W-1:0] shift_q;
	logic [SHIFT_W-1:0] cfg_q [CFG_NUM];
	logic [ADDR_W-1:0]  last_addr_q;
	logic [CNT_W-1:0]   loads_q;
	logic               soft_load;
	logic [SHIFT_W-1:0] soft_word;
	logic               load_en;
	logic [SHIFT_W-1:0] load_word;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			shift_q <= '0;
		end else if (sclk_rise) begin
			shift_q <= {shift_q[SHIFT_W-2:0], data_bit};
		end
	end

	// A strobe from the pins wins over a bus load in the same cycle
	assign load_en   = strobe_rise || soft_load;
	assign load_word = strobe_rise ? shift_q : soft_word;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < CFG_NUM; i++) begin
				cfg_q[i] <= CFG_RESET[i];
			end
		end else if (load_en) begin
			cfg_q[load_word[ADDR_LSB +: ADDR_W]] <= load_word;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			last_addr_q <= '0;
		end else if (load_en) begin
			last_addr_q <= load_word[ADDR_LSB +: ADDR_W];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			loads_q <= '0;
		end else if (load_en) begin
			loads_q <= loads_q + CNT_W'(1);
		end
	end

	// Control register
	logic [CTRL_W-1:0]    ctrl_q;
	logic [NUM_SYNTH-1:0] ref_bad;
	logic [NUM_SYNTH-1:0] fb_bad;
	logic [NUM_SYNTH-1:0] order_bad;

	// Per synthesizer settings and dividers
	for (genvar s = 0; s < NUM_SYNTH; s++) begin : gen_synth
		div_cfg_if             cfg_bus ();
		logic [NDIV_W-1:0]     n_total;
		logic [NDIV_W-1:0]     cont_min;

		assign cfg_bus.ref_value           = cfg_q[2*s][REF_LSB +: REF_W];
		assign cfg_bus.swallow_count_value = cfg_q[2*s+1][SWALLOW_LSB +: SWALLOW_W];
		assign cfg_bus.binary_count_value  = cfg_q[2*s+1][BINARY_LSB +: BINARY_W];
		assign cfg_bus.presc_high          = cfg_q[2*s+1][PRESC_BIT];
		assign cfg_bus.hold = ctrl_q[CTRL_PWDN_LSB + s] || ctrl_q[CTRL_HOLD_LSB + s];

		// Ratio checks for status only
		assign n_total = NDIV_W'(cfg_bus.presc_high ? BASE_HIGH : BASE_LOW)
			* NDIV_W'(cfg_bus.binary_count_value)
			+ NDIV_W'(cfg_bus.swallow_count_value);
		assign cont_min = cfg_bus.presc_high ? CONT_MIN_HIGH : CONT_MIN_LOW;
		assign ref_bad[s] = cfg_bus.ref_value < REF_MIN;
		assign fb_bad[s]  = cfg_bus.binary_count_value < BINARY_MIN;
		assign order_bad[s] = (n_total < cont_min)
			&& (cfg_bus.binary_count_value
				< BINARY_W'(cfg_bus.swallow_count_value));

		ref_divider u_ref (
			.aclk    (aclk),
			.aresetn (aresetn),
			.tick    (ref_tick),
			.cfg     (cfg_bus),
			.pulse   (comparison_ref[s])
		);

		feedback_divider u_fb (
			.aclk    (aclk),
			.aresetn (aresetn),
			.rf_tick (rf_tick[s]),
			.cfg     (cfg_bus),
			.pulse   (comparison_fb[s])
		);
	end

	// Comparison pulse counters, wrapping
	logic [CNT_W-1:0] ref_cnt_q [NUM_SYNTH];
	logic [CNT_W-1:0] fb_cnt_q  [NUM_SYNTH];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int s = 0; s < NUM_SYNTH; s++) begin
				ref_cnt_q[s] <= '0;
			end
		end else begin
			for (int s = 0; s < NUM_SYNTH; s++) begin
				if (comparison_ref[s]) begin
					ref_cnt_q[s] <= ref_cnt_q[s] + CNT_W'(1);
				end
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int s = 0; s < NUM_SYNTH; s++) begin
				fb_cnt_q[s] <= '0;
			end
		end else begin
			for (int s = 0; s < NUM_SYNTH; s++) begin
				if (comparison_fb[s]) begin
					fb_cnt_q[s] <= fb_cnt_q[s] + CNT_W'(1);
				end
			end
		end
	end

	// Register bus: write path
	logic                  aw_held_q;
	logic [AXI_ADDR_W-1:0] awaddr_q;
	logic                  w_held_q;
	logic [AXI_DATA_W-1:0] wdata_q;
	logic [3:0]            wstrb_q;
	logic                  bvalid_q;
	logic [1:0]            bresp_q;
	logic                  do_write;
	logic [AXI_ADDR_W-1:0] wr_addr;

	assign awready  = !aw_held_q && !bvalid_q;
	assign wready   = !w_held_q && !bvalid_q;
	assign do_write = aw_held_q && w_held_q && !bvalid_q;
	assign wr_addr  = {awaddr_q[AXI_ADDR_W-1:2], 2'h0};

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_q <= 1'b0;
			awaddr_q  <= '0;
		end else if (awvalid && awready) begin
			aw_held_q <= 1'b1;
			awaddr_q  <= awaddr;
		end else if (do_write) begin
			aw_held_q <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held_q <= 1'b0;
			wdata_q  <= '0;
			wstrb_q  <= '0;
		end else if (wvalid && wready) begin
			w_held_q <= 1'b1;
			wdata_q  <= wdata;
			wstrb_q  <= wstrb;
		end else if (do_write) begin
			w_held_q <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_q <= 1'b0;
			bresp_q  <= RESP_OKAY;
		end else if (do_write) begin
			bvalid_q <= 1'b1;
			bresp_q  <= (wr_addr == OFF_CTRL || wr_addr == OFF_LOAD) ? RESP_OKAY : RESP_SLVERR;
		end else if (bready) begin
			bvalid_q <= 1'b0;
		end
	end

	assign bvalid = bvalid_q;
	assign bresp  = bresp_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q <= CTRL_RESET;
		end else if (do_write && wr_addr == OFF_CTRL && wstrb_q[0]) begin
			ctrl_q <= wdata_q[CTRL_W-1:0];
		end
	end

	// Bus load of a whole word needs the three low byte lanes
	assign soft_load = do_write && wr_addr == OFF_LOAD && (wstrb_q[2:0] == 3'h7);
	assign soft_word = wdata_q[SHIFT_W-1:0];

	// Register bus: read path
	logic                  rvalid_q;
	logic [AXI_DATA_W-1:0] rdata_q;
	logic [1:0]            rresp_q;
	logic [AXI_DATA_W-1:0] rd_data;
	logic                  rd_ok;
	logic [AXI_ADDR_W-1:0] rd_addr;

	assign arready = !rvalid_q;
	assign rd_addr = {araddr[AXI_ADDR_W-1:2], 2'h0};

	always_comb begin
		rd_data = '0;
		rd_ok   = 1'b1;
		if (rd_addr == OFF_CTRL) begin
			rd_data[CTRL_W-1:0] = ctrl_q;
		end else if (rd_addr == OFF_STATUS) begin
			rd_data[STAT_ADDR_LSB +: ADDR_W]     = last_addr_q;
			rd_data[STAT_LOADS_LSB +: CNT_W]     = loads_q;
			rd_data[STAT_REFBAD_LSB +: NUM_SYNTH] = ref_bad;
			rd_data[STAT_FBBAD_LSB +: NUM_SYNTH]  = fb_bad;
			rd_data[STAT_ORDER_LSB +: NUM_SYNTH]  = order_bad;
		end else if (rd_addr == OFF_COUNTS) begin
			rd_data = {fb_cnt_q[1], ref_cnt_q[1], fb_cnt_q[0], ref_cnt_q[0]};
		end else if (rd_addr[AXI_ADDR_W-1:4] == OFF_CFG[AXI_ADDR_W-1:4]) begin
			rd_data[SHIFT_W-1:0] = cfg_q[rd_addr[3:2]];
		end else begin
			rd_ok = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
		end else if (arvalid && arready) begin
			rvalid_q <= 1'b1;
		end else if (rready) begin
			rvalid_q <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rdata_q <= '0;
			rresp_q <= RESP_OKAY;
		end else if (arvalid && arready) begin
			rdata_q <= rd_data;
			rresp_q <= rd_ok ? RESP_OKAY : RESP_SLVERR;
		end
	end

	assign rvalid = rvalid_q;
	assign rdata  = rdata_q;
	assign rresp  = rresp_q;
endmodule

// File: common/pll_div_pkg.sv
// Shared constants of the dual synthesizer divider chain
package pll_div_pkg;
	localparam int NUM_SYNTH = 2;
	localparam int REF_W     = 15;
	localparam int SWALLOW_W = 7;
	localparam int BINARY_W  = 11;
	localparam int SHIFT_W   = 22;
	localparam int CFG_NUM   = 4;
	localparam int PRE_W     = 8;
	localparam int NDIV_W    = 18;
	localparam int CNT_W     = 8;
	// Serial word fields
	localparam int ADDR_LSB    = 0;
	localparam int ADDR_W      = 2;
	localparam int REF_LSB     = 2;
	localparam int SWALLOW_LSB = 2;
	localparam int BINARY_LSB  = 9;
	localparam int PRESC_BIT   = 20;
	// Prescaler moduli and smallest continuous ratios
	localparam logic [PRE_W-1:0]     BASE_LOW      = 8'h40;
	localparam logic [PRE_W-1:0]     BASE_HIGH     = 8'h80;
	localparam logic [NDIV_W-1:0]    CONT_MIN_LOW  = 18'h0_0fc0;
	localparam logic [NDIV_W-1:0]    CONT_MIN_HIGH = 18'h0_3f80;
	localparam logic [REF_W-1:0]     REF_MIN       = 15'h0003;
	localparam logic [BINARY_W-1:0]  BINARY_MIN    = 11'h003;
	localparam logic [SHIFT_W-1:0]   CFG_RESET [CFG_NUM] =
		'{22'h00_000c, 22'h00_0601, 22'h00_000e, 22'h00_0603};
	// Register bus map
	localparam int AXI_ADDR_W = 8;
	localparam int AXI_DATA_W = 32;
	localparam logic [AXI_ADDR_W-1:0] OFF_CTRL   = 8'h00;
	localparam logic [AXI_ADDR_W-1:0] OFF_STATUS = 8'h04;
	localparam logic [AXI_ADDR_W-1:0] OFF_COUNTS = 8'h08;
	localparam logic [AXI_ADDR_W-1:0] OFF_LOAD   = 8'h0c;
	localparam logic [AXI_ADDR_W-1:0] OFF_CFG    = 8'h10;
	localparam int CTRL_W        = 4;
	localparam int CTRL_PWDN_LSB = 0;
	localparam int CTRL_HOLD_LSB = 2;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 4'h0;
	localparam int STAT_ADDR_LSB   = 0;
	localparam int STAT_LOADS_LSB  = 8;
	localparam int STAT_REFBAD_LSB = 16;
	localparam int STAT_FBBAD_LSB  = 18;
	localparam int STAT_ORDER_LSB  = 20;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// File: common/div_cfg_if.sv
// Divider settings of one synthesizer
`timescale 1ns/1ps
interface div_cfg_if;
	import pll_div_pkg::*;
	logic [REF_W-1:0]     ref_value;
	logic [SWALLOW_W-1:0] swallow_count_value;
	logic [BINARY_W-1:0]  binary_count_value;
	logic                 presc_high;
	logic                 hold;
	modport ctrl (output ref_value, swallow_count_value, binary_count_value, presc_high, hold);
	modport div  (input ref_value, swallow_count_value, binary_count_value, presc_high, hold);
endinterface

// File: rtl/ref_divider.sv
// Reference divider of one synthesizer
`timescale 1ns/1ps
module ref_divider (
	// Clock and reset
	input  wire logic aclk,
	input  wire logic aresetn,
	// Reference edge enable
	input  wire logic tick,
	// Settings
	div_cfg_if.div    cfg,
	// Comparison reference pulse
	output logic      pulse
);
	import pll_div_pkg::*;

	logic [REF_W-1:0] cnt_q;
	logic             pulse_q;

	always_ff @(posedge aclk) begin
		if (!aresetn || cfg.hold) begin
			cnt_q <= '0;
		end else if (tick) begin
			if (cnt_q == '0) begin
				cnt_q <= cfg.ref_value - REF_W'(1);
			end else begin
				cnt_q <= cnt_q - REF_W'(1);
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pulse_q <= 1'b0;
		end else begin
			pulse_q <= tick && (cnt_q == '0) && !cfg.hold;
		end
	end

	assign pulse = pulse_q;
endmodule

// File: rtl/feedback_divider.sv
// Dual-modulus prescaler with swallow and binary counters
`timescale 1ns/1ps
module feedback_divider (
	// Clock and reset
	input  wire logic aclk,
	input  wire logic aresetn,
	// Synthesizer input edge enable
	input  wire logic rf_tick,
	// Settings
	div_cfg_if.div    cfg,
	// Comparison feedback pulse
	output logic      pulse
);
	import pll_div_pkg::*;

	logic [PRE_W-1:0]     pre_q;
	logic [SWALLOW_W-1:0] swallow_q;
	logic [BINARY_W-1:0]  binary_q;
	logic                 pulse_q;
	logic [PRE_W-1:0]     modulus;
	logic                 presc_tick;

	// Base plus one while swallowing, base afterwards
	assign modulus = (cfg.presc_high ? BASE_HIGH : BASE_LOW)
		+ PRE_W'(swallow_q != '0);
	assign presc_tick = rf_tick && (pre_q == modulus - PRE_W'(1));

	always_ff @(posedge aclk) begin
		if (!aresetn || cfg.hold) begin
			pre_q <= '0;
		end else if (presc_tick) begin
			pre_q <= '0;
		end else if (rf_tick) begin
			pre_q <= pre_q + PRE_W'(1);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || cfg.hold) begin
			swallow_q <= cfg.swallow_count_value;
			binary_q  <= cfg.binary_count_value;
		end else if (presc_tick) begin
			if (binary_q <= BINARY_W'(1)) begin
				swallow_q <= cfg.swallow_count_value;
				binary_q  <= cfg.binary_count_value;
			end else begin
				binary_q <= binary_q - BINARY_W'(1);
				if (swallow_q != '0) begin
					swallow_q <= swallow_q - SWALLOW_W'(1);
				end
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pulse_q <= 1'b0;
		end else begin
			pulse_q <= presc_tick && (binary_q <= BINARY_W'(1)) && !cfg.hold;
		end
	end

	assign pulse = pulse_q;
endmodule

// File: test/dual_pll_divider_chain_sva.sv
// Bus handshake and divider output checks at the top ports
`timescale 1ns/1ps
module dual_pll_divider_chain_sva (
	// Clock and reset
	input wire logic                                 aclk,
	input wire logic                                 aresetn,
	// Register bus
	input wire logic                                 awvalid,
	input wire logic                                 awready,
	input wire logic                                 wvalid,
	input wire logic                                 wready,
	input wire logic [1:0]                           bresp,
	input wire logic                                 bvalid,
	input wire logic                                 bready,
	input wire logic [pll_div_pkg::AXI_ADDR_W-1:0]   araddr,
	input wire logic                                 arvalid,
	input wire logic                                 arready,
	input wire logic [pll_div_pkg::AXI_DATA_W-1:0]   rdata,
	input wire logic [1:0]                           rresp,
	input wire logic                                 rvalid,
	input wire logic                                 rready,
	// Pins and comparator inputs
	input wire logic                                 reference_clock_input,
	input wire logic [pll_div_pkg::NUM_SYNTH-1:0]    rf_input,
	input wire logic [pll_div_pkg::NUM_SYNTH-1:0]    comparison_ref,
	input wire logic [pll_div_pkg::NUM_SYNTH-1:0]    comparison_fb
);
	import pll_div_pkg::*;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_write_take; awvalid && awready && wvalid && wready; endsequence
	sequence s_read_take; arvalid && arready; endsequence

	property p_write_answer; s_write_take |-> ##2 bvalid; endproperty
	a_write_answer: assert property (p_write_answer) else $error("write answer late");
	property p_read_answer; s_read_take |=> rvalid; endproperty
	a_read_answer: assert property (p_read_answer) else $error("read answer late");
	property p_b_hold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
	a_b_hold: assert property (p_b_hold) else $error("write response dropped");
	property p_r_hold; rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp); endproperty
	a_r_hold: assert property (p_r_hold) else $error("read data dropped");
	property p_ar_block; rvalid |-> !arready; endproperty
	a_ar_block: assert property (p_ar_block) else $error("read taken while busy");
	property p_unmapped;
		s_read_take ##0 (araddr >= 8'h20) |=> rresp == RESP_SLVERR && rdata == 32'h0000_0000;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read answered");
	property p_ref_pulse; comparison_ref[0] |=> !comparison_ref[0]; endproperty
	a_ref_pulse: assert property (p_ref_pulse) else $error("reference pulse too long");
	property p_fb_pulse; comparison_fb[0] |=> !comparison_fb[0]; endproperty
	a_fb_pulse: assert property (p_fb_pulse) else $error("feedback pulse too long");
	property p_ref_src;
		$rose(comparison_ref[1]) |-> $past(reference_clock_input, 3) && !$past(reference_clock_input, 6);
	endproperty
	a_ref_src: assert property (p_ref_src) else $error("reference pulse off edge");
	property p_fb_src; $rose(comparison_fb[0]) |-> $past(rf_input[0], 3) && !$past(rf_input[0], 6); endproperty
	a_fb_src: assert property (p_fb_src) else $error("feedback pulse off edge");
endmodule

bind dual_pll_divider_chain dual_pll_divider_chain_sva chk (.aclk(aclk), .aresetn(aresetn),
	.awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready), .bresp(bresp),
	.bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
	.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
	.reference_clock_input(reference_clock_input), .rf_input(rf_input),
	.comparison_ref(comparison_ref), .comparison_fb(comparison_fb));

// File: test/serial_host.sv
// Serial programming host driving the three-wire port
`timescale 1ns/1ps
module serial_host (
	// Clock
	input  wire logic aclk,
	// Serial port
	output logic      serial_clock,
	output logic      serial_data,
	output logic      latch_strobe
);
	import pll_div_pkg::*;
	initial begin
		serial_clock = 1'b0;
		serial_data = 1'b0;
		latch_strobe = 1'b0;
	end
	// Each level holds four cycles; clock stands low between frames
	task automatic send(input logic [SHIFT_W-1:0] word);
		for (int i = SHIFT_W - 1; i >= 0; i--) begin
			serial_data <= word[i];
			repeat (4) @(posedge aclk);
			serial_clock <= 1'b1;
			repeat (4) @(posedge aclk);
			serial_clock <= 1'b0;
		end
		serial_data <= ~word[0];
		repeat (4) @(posedge aclk);
		latch_strobe <= 1'b1;
		repeat (4) @(posedge aclk);
		latch_strobe <= 1'b0;
	endtask
endmodule

// File: test/dual_pll_divider_chain_bench.sv
// Bench for the divider chain: bus, serial port and divider periods
`timescale 1ns/1ps
module dual_pll_divider_chain_bench;
	import pll_div_pkg::*;
	localparam int REF_PER = 8;
	localparam int RF_PER  = 6;
	logic                  aclk = 1'b0;
	logic                  aresetn = 1'b0;
	logic [AXI_ADDR_W-1:0] awaddr = '0, araddr = '0;
	logic [AXI_DATA_W-1:0] wdata = '0, rdata, got;
	logic [3:0]            wstrb = 4'hf;
	logic                  awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic                  awready, wready, bvalid, arready, rvalid;
	logic [1:0]            bresp, rresp, resp, ref_ph = '0, rf_ph = '0;
	logic                  ref_pin = 1'b0;
	logic [NUM_SYNTH-1:0]  rf_pin = '0, cmp_ref, cmp_fb;
	logic                  sclk, sdata, sle;
	logic [SHIFT_W-1:0]    w;
	int                    error_cnt = 0, comparisons = 0;

	always #2.5 aclk = ~aclk;
	always @(posedge aclk) begin
		ref_ph <= ref_ph + 2'h1;
		rf_ph <= (rf_ph == 2'h2) ? 2'h0 : rf_ph + 2'h1;
		if (ref_ph == 2'h3) ref_pin <= ~ref_pin;
		if (rf_ph == 2'h2) rf_pin <= ~rf_pin;
	end

	serial_host host (.aclk(aclk), .serial_clock(sclk), .serial_data(sdata), .latch_strobe(sle));
	dual_pll_divider_chain dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .reference_clock_input(ref_pin), .rf_input(rf_pin),
		.serial_clock(sclk), .serial_data(sdata), .latch_strobe(sle),
		.comparison_ref(cmp_ref), .comparison_fb(cmp_fb));

	task automatic print_verdict();
		$display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic fail_now();
		error_cnt++;
		$display("BAD %0t wait limit reached", $time);
		print_verdict();
	endtask
	task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			error_cnt++;
			$display("BAD %0t word %h expected %h", $time, g, e);
		end
	endtask
	task automatic chk_resp(input logic [1:0] g, input logic [1:0] e);
		comparisons++;
		if (g !== e) begin
			error_cnt++;
			$display("BAD %0t response %h expected %h", $time, g, e);
		end
	endtask
	// Ready is settled at the falling edge and unchanged until the next rise
	task automatic bus_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		bit a_hs, w_hs, done;
		int n;
		done = 0;
		n = 0;
		awaddr <= a; wdata <= d; wstrb <= s;
		awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
		while (!done) begin
			@(negedge aclk);
			a_hs = awvalid && awready;
			w_hs = wvalid && wready;
			done = bvalid;
			resp = bresp;
			@(posedge aclk);
			if (a_hs) awvalid <= 1'b0;
			if (w_hs) wvalid <= 1'b0;
			if (++n > 200) fail_now();
		end
		bready <= 1'b0;
		@(posedge aclk);
	endtask
	task automatic bus_read(input logic [7:0] a);
		bit a_hs, done;
		int n;
		done = 0;
		n = 0;
		araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
		while (!done) begin
			@(negedge aclk);
			a_hs = arvalid && arready;
			done = rvalid;
			got = rdata;
			resp = rresp;
			@(posedge aclk);
			if (a_hs) arvalid <= 1'b0;
			if (++n > 200) fail_now();
		end
		rready <= 1'b0;
		@(posedge aclk);
	endtask
	// First pulse aligns on a reload, the second interval is measured
	task automatic measure(input bit fb, input int idx, input int expect_cyc);
		int n;
		bit p;
		for (int k = 0; k < 2; k++) begin
			n = 0;
			do begin
				@(negedge aclk);
				p = fb ? cmp_fb[idx] : cmp_ref[idx];
				if (++n > 60000) fail_now();
			end while (p !== 1'b1);
		end
		chk_word(32'(n), 32'(expect_cyc));
		@(posedge aclk);
	endtask
	function automatic logic [SHIFT_W-1:0] ref_word(input int sel, input int r);
		return SHIFT_W'(sel + (r << REF_LSB));
	endfunction
	function automatic logic [SHIFT_W-1:0] fb_word(input int sel, b, a, p);
		return SHIFT_W'(sel + (a << SWALLOW_LSB) + (b << BINARY_LSB) + (p << PRESC_BIT));
	endfunction

	initial begin
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		for (int i = 0; i < CFG_NUM; i++) begin
			bus_read(OFF_CFG + 8'(4 * i));
			chk_word(got, 32'(CFG_RESET[i]));
		end
		bus_read(OFF_CTRL);
		chk_word(got, 32'(CTRL_RESET));
		bus_read(8'h20);
		chk_resp(resp, RESP_SLVERR);
		chk_word(got, 32'h0000_0000);
		bus_write(OFF_STATUS, 32'h0000_00ff, 4'hf);
		chk_resp(resp, RESP_SLVERR);
		// Serial loads while both synthesizers are powered down
		bus_write(OFF_CTRL, 32'h0000_0003, 4'hf);
		chk_resp(resp, RESP_OKAY);
		w = ref_word(0, 5);
		host.send(w);
		bus_read(OFF_CFG);
		chk_word(got, 32'(w));
		w = fb_word(1, 3, 2, 0);
		host.send(w);
		bus_read(OFF_CFG + 8'h04);
		chk_word(got, 32'(w));
		bus_read(OFF_STATUS);
		chk_word(got & 32'h003f_ff03, 32'h0000_0201);
		bus_write(OFF_CTRL, 32'h0000_0000, 4'hf);
		w = fb_word(3, 3, 1, 1);
		bus_write(OFF_LOAD, 32'(w), 4'hf);
		chk_resp(resp, RESP_OKAY);
		bus_read(OFF_CFG + 8'h0c);
		chk_word(got, 32'(w));
		// A load without all three low byte lanes leaves the word alone
		bus_write(OFF_LOAD, 32'(ref_word(2, 9)), 4'h3);
		chk_resp(resp, RESP_OKAY);
		bus_read(OFF_CFG + 8'h08);
		chk_word(got, 32'(CFG_RESET[2]));
		measure(0, 0, 5 * REF_PER);
		measure(0, 1, 3 * REF_PER);
		measure(1, 0, (64 * 3 + 2) * RF_PER);
		measure(1, 1, (128 * 3 + 1) * RF_PER);
		// Binary count kept at or above the swallow count
		host.send(fb_word(1, 64, 63, 0));
		measure(1, 0, (64 * 64 + 63) * RF_PER);
		print_verdict();
	end
endmodule
